// ### core/dmat_pkg.sv
// Shared constants, types and decode functions of the two-cycle transfer engine.
package dmat_pkg;

  // Number of channels of the engine.
  localparam int NCH = 8;

  // Data path width codes.
  localparam logic [1:0] WID_8 = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [1:0] WID_32 = 2'h2;

  // Data transfer modes.
  localparam logic [1:0] MODE_DEMAND = 2'h0;
  localparam logic [1:0] MODE_BLOCK = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;

  // Bus cycle types.
  localparam logic [1:0] CYC_READ = 2'h0;
  localparam logic [1:0] CYC_WRITE = 2'h1;
  localparam logic [1:0] CYC_VERIFY = 2'h2;

  // Buffer transfer modes.
  localparam logic [1:0] BUF_SINGLE = 2'h0;
  localparam logic [1:0] BUF_AUTO = 2'h1;
  localparam logic [1:0] BUF_CHAIN = 2'h2;

  // Extra bus states with hold kept high while current registers reload.
  localparam logic [2:0] RELOAD_CLOCKS = 3'h7;

  // Per-channel configuration word.
  typedef struct packed {
    logic [1:0] req_width;
    logic [1:0] tgt_width;
    logic [1:0] xfer_mode;
    logic [1:0] cycle_type;
    logic [1:0] buf_mode;
  } dmat_cfg_type;

  // Configuration after reset: 8-bit requester and 8-bit target.
  localparam dmat_cfg_type CFG_RESET = '{req_width: WID_8, tgt_width: WID_8, xfer_mode: MODE_DEMAND,
                                         cycle_type: CYC_READ, buf_mode: BUF_SINGLE};

  // Base register set of one channel; byte count is in bytes.
  typedef struct packed {
    logic [31:0] req_addr;
    logic [31:0] tgt_addr;
    logic [23:0] count;
  } dmat_base_type;

  // Width code to number of bytes.
  function automatic logic [2:0] width_bytes(input logic [1:0] w);
    width_bytes = (w == WID_32) ? 3'h4 : ((w == WID_16) ? 3'h2 : 3'h1);
  endfunction : width_bytes

  // Low-justified lane mask for n bytes.
  function automatic logic [3:0] lane_mask(input logic [2:0] n);
    lane_mask = (n >= 3'h4) ? 4'hF : ((n == 3'h3) ? 4'h7 : ((n == 3'h2) ? 4'h3 : ((n == 3'h1) ? 4'h1 : 4'h0)));
  endfunction : lane_mask

endpackage : dmat_pkg

// ### core/dmat_temp_store.sv
// Per-channel temporary register with byte assembly and fill level.
`timescale 1ns/1ps
module dmat_temp_store (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Channel selection
  input wire logic [2:0] sel,
  // Byte append, bytes low-justified
  input wire logic add_en,
  input wire logic [31:0] add_data,
  input wire logic [2:0] add_n,
  // Empty after the write to the destination
  input wire logic clr_en,
  // Contents of the selected channel
  output logic [31:0] data,
  output logic [2:0] fill
);

  logic [31:0] store_r [8];
  logic [2:0] fill_r [8];
  logic [31:0] keep;

  // Only the wanted bytes of the incoming word are kept.
  assign keep = add_data & {{8{lane_mask_b(add_n, 2'h3)}}, {8{lane_mask_b(add_n, 2'h2)}},
                            {8{lane_mask_b(add_n, 2'h1)}}, {8{lane_mask_b(add_n, 2'h0)}}};
  assign data = store_r[sel];
  assign fill = fill_r[sel];

  // One bit of the lane mask.
  function automatic logic lane_mask_b(input logic [2:0] n, input logic [1:0] b);
    logic [3:0] m;
    m = dmat_pkg::lane_mask(n);
    lane_mask_b = m[b];
  endfunction : lane_mask_b

  // Contents stay per channel so that a suspended channel resumes with its partial word.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        store_r[i] <= 32'h0;
        fill_r[i] <= 3'h0;
      end
    end else if (clr_en) begin
      store_r[sel] <= 32'h0;
      fill_r[sel] <= 3'h0;
    end else if (add_en) begin
      store_r[sel] <= store_r[sel] | (keep << {fill_r[sel], 3'h0});
      fill_r[sel] <= fill_r[sel] + add_n;
    end
  end

endmodule : dmat_temp_store

// ### core/dmat_engine.sv
// Eight-channel two-cycle transfer engine with hold handshake and process termination.
// Overview of operation
// - Read source into the channel temporary register, then write it out separately.
// - Unaligned addresses are split into byte groups and assembled or disassembled.
// - Fill the temporary register from the source before any destination write.
// - Terminal count or end of process flushes a partial temporary register.
// - A suspended channel keeps its partial temporary register until it resumes.
// - Byte source to word destination: four byte reads, then one 32-bit write.
// - Single mode releases the bus between requester cycles, writes before the fifth.
// - Widths reset to 8-bit and are set per channel, requester and target apart.
// - Read cycle moves target to requester, write cycle requester to target.
// - Verify cycles only read; no write is issued.
// - Hold rises one state after a line or software service request.
// - Priority resolves in the state after acknowledge; access starts the next state.
// - When done, drop hold, stop driving the bus and return to slave mode.
// - Hold is not raised again until acknowledge has gone low.
// - Count expiry, end of process or withdrawn request drop hold after the transfer.
// - End of process input ends a service like count expiry but does not pulse the line.
// - Demand runs while requested, block runs to the end, single releases each transfer.
// - Request ignored during count ending; auto-initialize keeps hold seven more clocks.
// - Single or empty chain: set mask, set status, clear software request, pulse line.
// - Auto-initialize and loaded chain reload current registers, mask unchanged.
// - Release between channel services; rehold one state after acknowledge drops.
`timescale 1ns/1ps
module dmat_engine (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Channel programming
  input wire logic [7:0] CFG_WRITE,
  input wire dmat_pkg::dmat_cfg_type CFG_DATA,
  input wire logic [7:0] BASE_WRITE,
  input wire dmat_pkg::dmat_base_type BASE_DATA,
  input wire logic [7:0] CHAIN_BASE_VALID,
  input wire logic [7:0] SW_REQ_SET,
  input wire logic [7:0] MASK_SET,
  input wire logic [7:0] MASK_CLR,
  input wire logic [7:0] TC_STATUS_CLR,
  // Channel status
  output logic [7:0] CH_MASK,
  output logic [7:0] TC_STATUS,
  output logic [7:0] SW_REQ,
  // Requesters
  input wire logic [7:0] CHANNEL_SERVICE_REQUEST,
  input wire logic END_OF_PROCESS_LINE_N_IN,
  output logic END_OF_PROCESS_LINE_N_OUT,
  output logic END_OF_PROCESS_LINE_N_OE,
  // Host hold handshake
  output logic HOLD,
  input wire logic HOLD_ACKNOWLEDGE,
  // Bus master side
  output logic BUS_OE,
  output logic BUS_REQ,
  output logic BUS_WRITE,
  output logic [31:0] BUS_ADDR,
  output logic [3:0] BYTE_LANE_ENABLES,
  output logic [31:0] BUS_WDATA,
  input wire logic [31:0] BUS_RDATA,
  input wire logic BUS_READY
);

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_HOLD = 8'h02,
    ST_ARB = 8'h04,
    ST_RD = 8'h08,
    ST_WR = 8'h10,
    ST_NEXT = 8'h20,
    ST_RELOAD = 8'h40,
    ST_RELEASE = 8'h80
  } dmat_state_type;

  dmat_state_type state_r;
  dmat_pkg::dmat_cfg_type cfg_r [8];
  dmat_pkg::dmat_base_type base_r [8];
  dmat_pkg::dmat_base_type cur_r [8];
  logic [7:0] mask_r, tcst_r, swreq_r;
  logic [2:0] ch_r, pick, sel;
  logic [2:0] n_r, rld_cnt_r;
  logic end_r, tc_r, eop_pulse_r;
  logic [31:0] addr_r, wdata_r;
  logic [3:0] be_r;
  logic write_r;
  logic [7:0] pending;
  logic [31:0] tdata;
  logic [2:0] fill, sw, dw, src_room, need, n_rd;
  logic [31:0] saddr, daddr;
  logic [23:0] cnt_left;
  logic verify, to_req, write_due, go_rd, go_wr, fin, reload, rd_done, wr_done;
  dmat_pkg::dmat_cfg_type cfg;

  // Lowest-numbered pending channel wins.
  function automatic logic [2:0] prio(input logic [7:0] p);
    prio = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (p[i]) begin
        prio = i[2:0];
      end
    end
  endfunction : prio

  // Line and software requests share one path; masked channels do not compete.
  assign pending = (CHANNEL_SERVICE_REQUEST | swreq_r) & ~mask_r;
  assign pick = prio(pending);
  assign sel = (state_r == ST_ARB) ? pick : ch_r;
  assign cfg = cfg_r[sel];
  assign verify = (cfg.cycle_type == dmat_pkg::CYC_VERIFY);
  // A read cycle sources from the target, a write cycle from the requester.
  assign to_req = (cfg.cycle_type != dmat_pkg::CYC_WRITE);
  assign saddr = to_req ? cur_r[sel].tgt_addr : cur_r[sel].req_addr;
  assign daddr = to_req ? cur_r[sel].req_addr : cur_r[sel].tgt_addr;
  assign sw = dmat_pkg::width_bytes(to_req ? cfg.tgt_width : cfg.req_width);
  assign dw = dmat_pkg::width_bytes(to_req ? cfg.req_width : cfg.tgt_width);
  assign cnt_left = cur_r[sel].count;

  // Access sizing: a source access never crosses its width boundary, and the fill target
  // ends at the destination boundary, so misaligned ends are split into byte groups.
  always_comb begin
    src_room = sw - {1'b0, saddr[1:0] & 2'(sw - 3'h1)};
    need = verify ? src_room : dw - {1'b0, daddr[1:0] & 2'(dw - 3'h1)};
    n_rd = src_room;
    if ((need - fill) < n_rd) begin
      n_rd = need - fill;
    end
    if (cnt_left < {21'h0, n_rd}) begin
      n_rd = cnt_left[2:0];
    end
  end

  // Write the temporary register when full for the destination, or flush it on an ending.
  assign write_due = !verify && (fill != 3'h0) && ((fill == need) || end_r);
  assign go_wr = (state_r == ST_NEXT) && write_due;
  assign fin = (state_r == ST_NEXT) && end_r && !write_due;
  assign go_rd = ((state_r == ST_ARB) && (|pending)) || ((state_r == ST_NEXT) && !write_due && !end_r &&
                 (cfg.xfer_mode == dmat_pkg::MODE_BLOCK ||
                  (cfg.xfer_mode == dmat_pkg::MODE_DEMAND && CHANNEL_SERVICE_REQUEST[ch_r])));
  assign reload = (cfg.buf_mode == dmat_pkg::BUF_AUTO) ||
                  (cfg.buf_mode == dmat_pkg::BUF_CHAIN && CHAIN_BASE_VALID[ch_r]);
  assign rd_done = (state_r == ST_RD) && BUS_READY;
  assign wr_done = (state_r == ST_WR) && BUS_READY;

  dmat_temp_store u_temp (
    .clock(CLOCK),
    .rst(RST),
    .sel(sel),
    .add_en(rd_done && !verify),
    .add_data(BUS_RDATA >> {addr_r[1:0], 3'h0}),
    .add_n(n_r),
    .clr_en(wr_done),
    .data(tdata),
    .fill(fill)
  );

  // Main sequencer; the bus is given back between services of different channels.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if ((|pending) && !HOLD_ACKNOWLEDGE) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (HOLD_ACKNOWLEDGE) begin
            state_r <= ST_ARB;
          end
        end
        ST_ARB: begin
          state_r <= (|pending) ? ST_RD : ST_RELEASE;
        end
        ST_RD: begin
          if (BUS_READY) begin
            state_r <= ST_NEXT;
          end
        end
        ST_WR: begin
          if (BUS_READY) begin
            state_r <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (go_wr) begin
            state_r <= ST_WR;
          end else if (go_rd) begin
            state_r <= ST_RD;
          end else if (fin && reload) begin
            state_r <= ST_RELOAD;
          end else begin
            state_r <= ST_RELEASE;
          end
        end
        ST_RELOAD: begin
          if (rld_cnt_r == dmat_pkg::RELOAD_CLOCKS) begin
            state_r <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (!HOLD_ACKNOWLEDGE) begin
            state_r <= (|pending) ? ST_HOLD : ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Reload counter; hold stays up while the current registers are rebuilt.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rld_cnt_r <= 3'h0;
    end else if (state_r == ST_RELOAD) begin
      rld_cnt_r <= rld_cnt_r + 3'h1;
    end else begin
      rld_cnt_r <= 3'h1;
    end
  end

  // Channel latch and ending flags; the request line is not looked at once an ending is seen.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ch_r <= 3'h0;
      end_r <= 1'b0;
      tc_r <= 1'b0;
    end else if (state_r == ST_ARB) begin
      ch_r <= pick;
      end_r <= 1'b0;
      tc_r <= 1'b0;
    end else if (rd_done || wr_done) begin
      if (rd_done && cnt_left == {21'h0, n_r}) begin
        end_r <= 1'b1;
        tc_r <= 1'b1;
      end
      if (!END_OF_PROCESS_LINE_N_IN) begin
        end_r <= 1'b1;
      end
    end
  end

  // Bus cycle registers, loaded as each access is launched.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      addr_r <= 32'h0;
      be_r <= 4'h0;
      wdata_r <= 32'h0;
      write_r <= 1'b0;
      n_r <= 3'h0;
    end else if (go_wr) begin
      addr_r <= daddr;
      be_r <= dmat_pkg::lane_mask(fill) << daddr[1:0];
      wdata_r <= tdata << {daddr[1:0], 3'h0};
      write_r <= 1'b1;
      n_r <= fill;
    end else if (go_rd) begin
      addr_r <= saddr;
      be_r <= dmat_pkg::lane_mask(n_rd) << saddr[1:0];
      write_r <= 1'b0;
      n_r <= n_rd;
    end
  end

  // Channel configuration, base and current registers; reload copies base into current.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < dmat_pkg::NCH; i++) begin
        cfg_r[i] <= dmat_pkg::CFG_RESET;
        base_r[i] <= '0;
        cur_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < dmat_pkg::NCH; i++) begin
        if (CFG_WRITE[i]) begin
          cfg_r[i] <= CFG_DATA;
        end
        if (BASE_WRITE[i]) begin
          base_r[i] <= BASE_DATA;
          cur_r[i] <= BASE_DATA;
        end
      end
      if (rd_done) begin
        cur_r[ch_r].count <= cur_r[ch_r].count - {21'h0, n_r};
        if (to_req) begin
          cur_r[ch_r].tgt_addr <= cur_r[ch_r].tgt_addr + {29'h0, n_r};
        end else begin
          cur_r[ch_r].req_addr <= cur_r[ch_r].req_addr + {29'h0, n_r};
        end
      end else if (wr_done) begin
        if (to_req) begin
          cur_r[ch_r].req_addr <= cur_r[ch_r].req_addr + {29'h0, n_r};
        end else begin
          cur_r[ch_r].tgt_addr <= cur_r[ch_r].tgt_addr + {29'h0, n_r};
        end
      end else if (fin && reload) begin
        cur_r[ch_r] <= base_r[ch_r];
      end
    end
  end

  // Mask, status and software request; a software set wins over the clear by hardware.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      mask_r <= 8'hFF;
      tcst_r <= 8'h00;
      swreq_r <= 8'h00;
    end else begin
      for (int i = 0; i < dmat_pkg::NCH; i++) begin
        if (fin && ch_r == i[2:0] && !reload) begin
          mask_r[i] <= 1'b1;
        end else if (MASK_SET[i]) begin
          mask_r[i] <= 1'b1;
        end else if (MASK_CLR[i]) begin
          mask_r[i] <= 1'b0;
        end
        if (fin && ch_r == i[2:0] && cfg.buf_mode != dmat_pkg::BUF_CHAIN) begin
          tcst_r[i] <= 1'b1;
        end else if (fin && ch_r == i[2:0] && !reload) begin
          tcst_r[i] <= 1'b1;
        end else if (TC_STATUS_CLR[i]) begin
          tcst_r[i] <= 1'b0;
        end
        if (SW_REQ_SET[i]) begin
          swreq_r[i] <= 1'b1;
        end else if (fin && ch_r == i[2:0] && !(cfg.buf_mode == dmat_pkg::BUF_CHAIN && reload)) begin
          swreq_r[i] <= 1'b0;
        end
      end
    end
  end

  // End-of-process line is pulled low for one state on a count ending, except loaded chains.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      eop_pulse_r <= 1'b0;
    end else begin
      eop_pulse_r <= fin && tc_r && !(cfg.buf_mode == dmat_pkg::BUF_CHAIN && reload);
    end
  end

  // The bus is driven only while hold is up and the engine is master.
  assign HOLD = (state_r != ST_IDLE) && (state_r != ST_RELEASE);
  assign BUS_OE = HOLD && (state_r != ST_HOLD);
  assign BUS_REQ = (state_r == ST_RD) || (state_r == ST_WR);
  assign BUS_WRITE = write_r;
  assign BUS_ADDR = addr_r;
  assign BYTE_LANE_ENABLES = be_r;
  assign BUS_WDATA = wdata_r;
  assign CH_MASK = mask_r;
  assign TC_STATUS = tcst_r;
  assign SW_REQ = swreq_r;
  assign END_OF_PROCESS_LINE_N_OUT = 1'b0;
  assign END_OF_PROCESS_LINE_N_OE = eop_pulse_r;

  // Hold rises one state after a request seen while idle.
  a_hold_after_req: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == ST_IDLE && (|pending) && !HOLD_ACKNOWLEDGE) |=> HOLD) else $error("hold late");

  // Hold never rises while acknowledge is still high.
  a_no_early_hold: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(HOLD) |-> !$past(HOLD_ACKNOWLEDGE)) else $error("hold before ack low");

  // First access begins the state after arbitration.
  a_first_access: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == ST_ARB && (|pending)) |=> (BUS_REQ && !BUS_WRITE)) else $error("first access late");

  // Verify never writes.
  a_verify_nowrite: assert property (@(posedge CLOCK) disable iff (RST)
    (BUS_REQ && cfg_r[ch_r].cycle_type == dmat_pkg::CYC_VERIFY) |-> !BUS_WRITE) else $error("verify wrote");

  // Bus released whenever hold is low.
  a_bus_released: assert property (@(posedge CLOCK) disable iff (RST)
    !HOLD |-> (!BUS_OE && !BUS_REQ)) else $error("bus driven without hold");

  // Reload keeps hold for seven states, then releases.
  a_reload_len: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(state_r == ST_RELOAD) |-> (HOLD && state_r == ST_RELOAD)[*7] ##1 (state_r == ST_RELEASE))
    else $error("reload length");

  // A non-reloading ending masks the channel and sets its status.
  a_end_masks: assert property (@(posedge CLOCK) disable iff (RST)
    (fin && !reload) |=> (CH_MASK[$past(ch_r)] && TC_STATUS[$past(ch_r)] && !HOLD)) else $error("end effects");

  // Partial data is flushed before the process ends.
  a_partial_flush: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == ST_NEXT && end_r && !verify && fill != 3'h0) |=> (BUS_REQ && BUS_WRITE))
    else $error("partial data lost");

  // Single mode gives the bus back after a read that does not fill the register.
  a_single_release: assert property (@(posedge CLOCK) disable iff (RST)
    (state_r == ST_NEXT && !write_due && !(fin && reload) && cfg.xfer_mode == dmat_pkg::MODE_SINGLE) |=> !HOLD)
    else $error("single kept bus");

endmodule : dmat_engine

// ### sim/dmat_host_model.sv
// Host processor and bus memory model that face the transfer engine.
`timescale 1ns/1ps
module dmat_host_model (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Hold handshake
  input wire logic HOLD,
  output logic HOLD_ACKNOWLEDGE,
  // Bus slave side
  input wire logic BUS_REQ,
  input wire logic [31:0] BUS_ADDR,
  input wire logic SLOW,
  output logic [31:0] BUS_RDATA,
  output logic BUS_READY
);
  logic [1:0] wait_r;
  logic [31:0] pat_r;
  logic [7:0] base;

  // The host grants one state after hold rises and withdraws one state after hold falls.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      HOLD_ACKNOWLEDGE <= 1'b0;
    end else begin
      HOLD_ACKNOWLEDGE <= HOLD;
    end
  end

  // Memory answers promptly, or two states late when asked to be slow.
  assign base = {BUS_ADDR[7:2], 2'h0};
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wait_r <= 2'h0;
      BUS_READY <= 1'b0;
      pat_r <= 32'h0;
    end else if (BUS_REQ && !BUS_READY && wait_r == (SLOW ? 2'h2 : 2'h0)) begin
      BUS_READY <= 1'b1;
      pat_r <= {base + 8'h3, base + 8'h2, base + 8'h1, base};
      wait_r <= 2'h0;
    end else begin
      BUS_READY <= 1'b0;
      wait_r <= (BUS_REQ && !BUS_READY) ? wait_r + 2'h1 : 2'h0;
    end
  end

  // Outside an answer the data lines carry the inverse, so stale data never looks valid.
  assign BUS_RDATA = BUS_READY ? pat_r : ~pat_r;
endmodule : dmat_host_model

// ### sim/dmat_engine_test.sv
// Self-checking testbench of the two-cycle transfer engine.
`timescale 1ns/1ps
module dmat_engine_test;
  logic CLOCK = 1'b0, RST = 1'b1, SLOW = 1'b0, eop_drive = 1'b1;
  logic [7:0] CFG_WRITE = 8'h0, BASE_WRITE = 8'h0, CHAIN_BASE_VALID = 8'h0, SW_REQ_SET = 8'h0;
  logic [7:0] MASK_SET = 8'h0, MASK_CLR = 8'h0, TC_STATUS_CLR = 8'h0, CHANNEL_SERVICE_REQUEST = 8'h0;
  logic [7:0] CH_MASK, TC_STATUS, SW_REQ;
  dmat_pkg::dmat_cfg_type CFG_DATA = dmat_pkg::CFG_RESET;
  dmat_pkg::dmat_base_type BASE_DATA = '0;
  logic EOP_OUT, EOP_OE, HOLD, ACK, BUS_OE, BUS_REQ, BUS_WRITE, BUS_READY, eop_wire, hold_q;
  logic [31:0] BUS_ADDR, BUS_WDATA, BUS_RDATA, wdata, waddr, raddr;
  logic [3:0] BE, wbe;
  int err_count = 0, checked = 0, rd_n, wr_n, eop_n, hold_len, hold_n, i;

  initial forever #2 CLOCK = ~CLOCK;
  // The end-of-process pin is pulled high; either party may pull it low.
  assign eop_wire = (EOP_OE ? EOP_OUT : 1'b1) & eop_drive;

  dmat_engine i_dmat_engine (.CLOCK(CLOCK), .RST(RST), .CFG_WRITE(CFG_WRITE), .CFG_DATA(CFG_DATA),
    .BASE_WRITE(BASE_WRITE), .BASE_DATA(BASE_DATA), .CHAIN_BASE_VALID(CHAIN_BASE_VALID),
    .SW_REQ_SET(SW_REQ_SET), .MASK_SET(MASK_SET), .MASK_CLR(MASK_CLR), .TC_STATUS_CLR(TC_STATUS_CLR),
    .CH_MASK(CH_MASK), .TC_STATUS(TC_STATUS), .SW_REQ(SW_REQ), .CHANNEL_SERVICE_REQUEST(CHANNEL_SERVICE_REQUEST),
    .END_OF_PROCESS_LINE_N_IN(eop_wire), .END_OF_PROCESS_LINE_N_OUT(EOP_OUT),
    .END_OF_PROCESS_LINE_N_OE(EOP_OE), .HOLD(HOLD), .HOLD_ACKNOWLEDGE(ACK), .BUS_OE(BUS_OE),
    .BUS_REQ(BUS_REQ), .BUS_WRITE(BUS_WRITE), .BUS_ADDR(BUS_ADDR), .BYTE_LANE_ENABLES(BE),
    .BUS_WDATA(BUS_WDATA), .BUS_RDATA(BUS_RDATA), .BUS_READY(BUS_READY));
  dmat_host_model i_dmat_host_model (.CLOCK(CLOCK), .RST(RST), .HOLD(HOLD), .HOLD_ACKNOWLEDGE(ACK),
    .BUS_REQ(BUS_REQ), .BUS_ADDR(BUS_ADDR), .SLOW(SLOW), .BUS_RDATA(BUS_RDATA), .BUS_READY(BUS_READY));

  // Bus monitor: tallies finished accesses, end pulses and hold tenures.
  always @(posedge CLOCK) begin
    hold_q <= HOLD;
    if (HOLD === 1'b1 && hold_q === 1'b0 && ACK !== 1'b0) begin
      err_count++;
      $display("unexpected hold at %0t: ack %h exp %h", $time, ACK, 1'b0);
    end
    if (HOLD === 1'b1) hold_len++;
    if (HOLD === 1'b1 && hold_q === 1'b0) hold_n++;
    if (EOP_OE === 1'b1) eop_n++;
    if (BUS_REQ === 1'b1 && BUS_READY === 1'b1) begin
      if (BUS_WRITE === 1'b1) begin
        wr_n++;
        wdata = BUS_WDATA;
        wbe = BE;
        waddr = BUS_ADDR;
      end else begin
        if (rd_n == 0) raddr = BUS_ADDR;
        rd_n++;
      end
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Programs one channel, raises its request and runs until the bus goes quiet.
  task automatic run(input int ch, input dmat_pkg::dmat_cfg_type cfg, input logic [31:0] ra, input logic [31:0] ta,
                     input logic [23:0] cnt, input logic sw, input logic keep);
    int quiet;
    @(posedge CLOCK);
    CFG_WRITE <= 8'h1 << ch;
    BASE_WRITE <= 8'h1 << ch;
    MASK_CLR <= 8'h1 << ch;
    CFG_DATA <= cfg;
    BASE_DATA <= '{req_addr: ra, tgt_addr: ta, count: cnt};
    @(posedge CLOCK);
    {CFG_WRITE, BASE_WRITE, MASK_CLR, TC_STATUS_CLR} <= 32'h0;
    {rd_n, wr_n, eop_n, hold_len, hold_n} = 160'h0;
    if (sw) SW_REQ_SET <= 8'h1 << ch;
    else CHANNEL_SERVICE_REQUEST <= 8'h1 << ch;
    @(posedge CLOCK);
    SW_REQ_SET <= 8'h0;
    @(posedge CLOCK);
    #1 chk(HOLD, 1'b1);
    quiet = 0;
    for (i = 0; i < 600 && quiet < 12; i++) begin
      @(posedge CLOCK);
      if (HOLD === 1'b0 && !keep) CHANNEL_SERVICE_REQUEST <= 8'h0;
      quiet = (HOLD === 1'b0) ? quiet + 1 : 0;
    end
    CHANNEL_SERVICE_REQUEST <= 8'h0;
    chk(quiet, 12);
  endtask : run

  function automatic dmat_pkg::dmat_cfg_type mk(input logic [1:0] rw, input logic [1:0] tw, input logic [1:0] xm,
                                                input logic [1:0] ct, input logic [1:0] bm);
    mk = '{req_width: rw, tgt_width: tw, xfer_mode: xm, cycle_type: ct, buf_mode: bm};
  endfunction : mk

  task automatic t_reset;
    chk(CH_MASK, 8'hFF);
    chk({TC_STATUS, SW_REQ, 7'h0, HOLD}, 24'h0);
  endtask : t_reset

  // Byte target into word requester: four byte reads, then one assembled word write.
  task automatic t_assemble;
    run(1, mk(dmat_pkg::WID_32, dmat_pkg::WID_8, dmat_pkg::MODE_BLOCK, dmat_pkg::CYC_READ, dmat_pkg::BUF_SINGLE),
        32'h200, 32'h100, 24'h4, 1'b0, 1'b0);
    chk(rd_n, 4);
    chk({wr_n, wbe, waddr}, {32'h1, 4'hF, 32'h200});
    chk(wdata, 32'h03020100);
    chk({TC_STATUS[1], CH_MASK[1], eop_n}, {2'h3, 32'h1});
  endtask : t_assemble

  // Count runs out with three bytes collected; slow memory stretches each access.
  task automatic t_partial;
    SLOW <= 1'b1;
    run(2, mk(dmat_pkg::WID_32, dmat_pkg::WID_8, dmat_pkg::MODE_DEMAND, dmat_pkg::CYC_READ, dmat_pkg::BUF_SINGLE),
        32'h400, 32'h180, 24'h3, 1'b0, 1'b1);
    SLOW <= 1'b0;
    chk({rd_n, wr_n, wbe}, {32'h3, 32'h1, 4'h7});
    chk(wdata & 32'h00FFFFFF, 32'h00828180);
  endtask : t_partial

  // A suspended single service keeps its byte for the next service.
  task automatic t_suspend;
    run(2, mk(dmat_pkg::WID_32, dmat_pkg::WID_8, dmat_pkg::MODE_SINGLE, dmat_pkg::CYC_READ, dmat_pkg::BUF_SINGLE),
        32'hB00, 32'h100, 24'h4, 1'b0, 1'b0);
    run(2, mk(dmat_pkg::WID_32, dmat_pkg::WID_8, dmat_pkg::MODE_BLOCK, dmat_pkg::CYC_READ, dmat_pkg::BUF_SINGLE),
        32'hB00, 32'h101, 24'h3, 1'b0, 1'b0);
    chk({rd_n, wr_n, wdata}, {32'h3, 32'h1, 32'h03020100});
  endtask : t_suspend

  task automatic t_verify;
    run(3, mk(dmat_pkg::WID_8, dmat_pkg::WID_8, dmat_pkg::MODE_BLOCK, dmat_pkg::CYC_VERIFY, dmat_pkg::BUF_SINGLE),
        32'h500, 32'h140, 24'h4, 1'b0, 1'b0);
    chk({rd_n, wr_n}, {32'h4, 32'h0});
  endtask : t_verify

  // A write cycle reads the requester and writes the target.
  task automatic t_direction;
    run(4, mk(dmat_pkg::WID_8, dmat_pkg::WID_32, dmat_pkg::MODE_BLOCK, dmat_pkg::CYC_WRITE, dmat_pkg::BUF_SINGLE),
        32'h300, 32'h600, 24'h4, 1'b0, 1'b0);
    chk({raddr, waddr}, {32'h300, 32'h600});
  endtask : t_direction

  // The peripheral ends the process after one byte; the partial byte is still written.
  task automatic t_eop;
    eop_drive <= 1'b0;
    run(5, mk(dmat_pkg::WID_32, dmat_pkg::WID_8, dmat_pkg::MODE_BLOCK, dmat_pkg::CYC_READ, dmat_pkg::BUF_SINGLE),
        32'h700, 32'h1C0, 24'h8, 1'b0, 1'b0);
    eop_drive <= 1'b1;
    chk({rd_n, wr_n, wbe, eop_n}, {32'h1, 32'h1, 4'h1, 32'h0});
    chk({TC_STATUS[5], CH_MASK[5]}, 2'h3);
  endtask : t_eop

  // Auto-initialize keeps hold seven states longer and leaves the mask open.
  task automatic t_auto;
    int h1;
    run(6, mk(dmat_pkg::WID_8, dmat_pkg::WID_8, dmat_pkg::MODE_BLOCK, dmat_pkg::CYC_READ, dmat_pkg::BUF_SINGLE),
        32'h800, 32'h100, 24'h1, 1'b0, 1'b0);
    h1 = hold_len;
    run(6, mk(dmat_pkg::WID_8, dmat_pkg::WID_8, dmat_pkg::MODE_BLOCK, dmat_pkg::CYC_READ, dmat_pkg::BUF_AUTO),
        32'h800, 32'h100, 24'h1, 1'b0, 1'b0);
    chk(hold_len - h1, 7);
    chk({CH_MASK[6], TC_STATUS[6], eop_n}, {2'h1, 32'h1});
  endtask : t_auto

  // Loaded chain base: no status, no pulse, mask untouched.
  task automatic t_chain;
    TC_STATUS_CLR <= 8'hFF;
    CHAIN_BASE_VALID <= 8'h80;
    run(7, mk(dmat_pkg::WID_8, dmat_pkg::WID_8, dmat_pkg::MODE_BLOCK, dmat_pkg::CYC_READ, dmat_pkg::BUF_CHAIN),
        32'h900, 32'h100, 24'h2, 1'b0, 1'b0);
    chk({TC_STATUS, CH_MASK[7], eop_n}, 41'h0);
  endtask : t_chain

  // Single mode with the request held: one tenure per byte read, word written within the fourth.
  task automatic t_single_sw;
    run(0, mk(dmat_pkg::WID_32, dmat_pkg::WID_8, dmat_pkg::MODE_SINGLE, dmat_pkg::CYC_READ, dmat_pkg::BUF_SINGLE),
        32'hA00, 32'h100, 24'h4, 1'b1, 1'b1);
    chk({hold_n, rd_n, wr_n}, {32'h4, 32'h4, 32'h1});
    chk({SW_REQ[0], CH_MASK[0]}, 2'h1);
  endtask : t_single_sw

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  initial begin
    repeat (6) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    t_reset();
    t_assemble();
    t_partial();
    t_suspend();
    t_verify();
    t_direction();
    t_eop();
    t_auto();
    t_chain();
    t_single_sw();
    complete_run();
  end

  // Watchdog: the scenarios need a few thousand cycles at most.
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
endmodule : dmat_engine_test
